//--- hw/sac_adc_ctrl.sv
// Summary of operation
// - Produce 8-bit result by successive approximation
// - Start write begins conversion, clears done
// - Done set at completion; result valid then
// - One conversion per start command
// - Start during conversion restarts at once
// - Start bit is write-only, reads zero
// - Done with enable raises interrupt request
// - Power bit enables converter, else idle
// - Reset aborts, control 40h, interrupt masked
// - Conversion clock divides by 12 or 6
// - Oscillator stop bit switches oscillator off
// - Control bit layout fixed, bits 1-0 reserved
// - Result register read-only, bits 7 to 0
// - Converter keeps running in WAIT
// - Sync option delays start until WAIT
`timescale 1ns/1ps
module sac_adc_ctrl (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // Register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   // Analog front end
   input  wire logic       compHigh,
   output logic      [7:0] dacCode,
   output logic            converterPowerOn,
   // Core and clock system
   input  wire logic       waitSyncOpt,
   input  wire logic       coreInWait,
   output logic            mainOscStop,
   // Interrupt
   output logic            irqReq
);
   // =====================================================
   // Storage
   sac_pkg::sac_ctl_state_t state;
   logic                    irqEn;
   logic                    eoc;
   logic                    pwrOn;
   logic                    fastClk;
   logic [7:0]              result;
   logic [1:0]              status;
   logic [1:0]              mask;
   logic [3:0]              divCnt;
   logic                    compMeta;
   logic                    compSync;
   logic                    startPulse;
   logic                    abortPulse;
   logic                    tickPulse;

   sac_sar_if sar ();

   sac_sar_core u_core (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .sar     (sar.core)
   );

   // =====================================================
   // Decode
   logic wrCtrl;
   logic wrMask;
   logic startReq;
   logic powerDown;
   logic doneTake;
   logic restartEv;
   logic rdStatus;
   logic [3:0] divLast;

   // Strobe aimed at one register
   function automatic logic regHit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
      regHit = strobe && (addr == target);
   endfunction : regHit

   assign wrCtrl    = regHit(regWr, regAddr, sac_pkg::ADDR_CTRL);
   assign wrMask    = regHit(regWr, regAddr, sac_pkg::ADDR_MASK);
   assign startReq  = wrCtrl && regWrData[sac_pkg::BIT_START]
                      && regWrData[sac_pkg::BIT_PWR];
   assign powerDown = wrCtrl && !regWrData[sac_pkg::BIT_PWR];
   // A done from an abandoned conversion is never taken
   assign doneTake  = sar.done && (state == sac_pkg::CS_RUN)
                      && !startPulse && !startReq && !powerDown;
   assign restartEv = startReq && (state != sac_pkg::CS_IDLE);
   assign rdStatus  = regHit(regRd, regAddr, sac_pkg::ADDR_STATUS);
   assign divLast   = fastClk ? sac_pkg::DIV_FAST_LAST
                              : sac_pkg::DIV_SLOW_LAST;

   assign sar.start    = startPulse;
   assign sar.abort    = abortPulse;
   assign sar.tick     = tickPulse;
   assign sar.compHigh = compSync;
   assign dacCode      = sar.trial;
   assign converterPowerOn = pwrOn;

   // =====================================================
   // Comparator synchroniser
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         compMeta <= 1'b0;
         compSync <= 1'b0;
      end else begin
         compMeta <= compHigh;
         compSync <= compMeta;
      end
   end

   // =====================================================
   // Control register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqEn       <= sac_pkg::CTRL_RESET[sac_pkg::BIT_IRQ_EN];
         pwrOn       <= sac_pkg::CTRL_RESET[sac_pkg::BIT_PWR];
         fastClk     <= sac_pkg::CTRL_RESET[sac_pkg::BIT_FAST];
         mainOscStop <= sac_pkg::CTRL_RESET[sac_pkg::BIT_OSC];
      end else if (wrCtrl) begin
         irqEn       <= regWrData[sac_pkg::BIT_IRQ_EN];
         pwrOn       <= regWrData[sac_pkg::BIT_PWR];
         fastClk     <= regWrData[sac_pkg::BIT_FAST];
         mainOscStop <= regWrData[sac_pkg::BIT_OSC];
      end
   end

   // =====================================================
   // Done flag and result
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         eoc    <= sac_pkg::CTRL_RESET[sac_pkg::BIT_DONE];
         result <= '0;
      end else if (startReq) begin
         eoc <= 1'b0;
      end else if (doneTake) begin
         eoc    <= 1'b1;
         result <= sar.result;
      end
   end

   // =====================================================
   // Sequencer
   always_ff @(posedge sys_clk) begin
      startPulse <= 1'b0;
      abortPulse <= 1'b0;
      if (!reset_n) begin
         state      <= sac_pkg::CS_IDLE;
         abortPulse <= 1'b1;
      end else if (powerDown) begin
         state      <= sac_pkg::CS_IDLE;
         abortPulse <= 1'b1;
      end else if (startReq) begin
         if (waitSyncOpt) begin
            state      <= sac_pkg::CS_SYNC;
            abortPulse <= 1'b1;
         end else begin
            state      <= sac_pkg::CS_RUN;
            startPulse <= 1'b1;
         end
      end else begin
         unique case (state)
            sac_pkg::CS_IDLE: begin
            end
            sac_pkg::CS_SYNC: begin
               if (coreInWait) begin
                  state      <= sac_pkg::CS_RUN;
                  startPulse <= 1'b1;
               end
            end
            sac_pkg::CS_RUN: begin
               // Continues regardless of WAIT
               if (doneTake) begin
                  state <= sac_pkg::CS_IDLE;
               end
            end
            default: state <= sac_pkg::CS_IDLE;
         endcase
      end
   end

   // =====================================================
   // Conversion clock divider
   always_ff @(posedge sys_clk) begin
      tickPulse <= 1'b0;
      if (!reset_n || startPulse || state != sac_pkg::CS_RUN) begin
         divCnt <= '0;
      end else if (divCnt >= divLast) begin
         divCnt    <= '0;
         tickPulse <= 1'b1;
      end else begin
         divCnt <= divCnt + 4'h1;
      end
   end

   // =====================================================
   // Event status, mask, interrupt
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         status <= '0;
         mask   <= sac_pkg::MASK_RESET;
      end else begin
         status <= (status & {sac_pkg::STAT_W{!rdStatus}})
                   | {restartEv, doneTake};
         if (wrMask) begin
            mask <= regWrData[1:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= irqEn && |(status & mask);
      end
   end

   // =====================================================
   // Read port
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !regRd) begin
         regRdData <= '0;
      end else begin
         unique case (regAddr)
            sac_pkg::ADDR_RESULT: regRdData <= result;
            sac_pkg::ADDR_CTRL:   regRdData <= {irqEn, eoc, 1'b0, pwrOn,
                                     fastClk, mainOscStop, 2'h0};
            sac_pkg::ADDR_STATUS: regRdData <= {6'h00, status};
            sac_pkg::ADDR_MASK:   regRdData <= {6'h00, mask};
            default:              regRdData <= '0;
         endcase
      end
   end

   // =====================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_start_clears_done: assert property (
      startReq |=> !eoc)
      else $error("done not cleared by start");

   a_done_sets_flag: assert property (
      doneTake |=> eoc && result == $past(sar.result))
      else $error("done or result not loaded");

   a_result_stable: assert property (
      !doneTake |=> $stable(result))
      else $error("result changed outside done");

   a_single_conv: assert property (
      state == sac_pkg::CS_IDLE && !startReq |=> !startPulse)
      else $error("conversion started without command");

   a_restart_now: assert property (
      startReq && !waitSyncOpt |=> startPulse && state == sac_pkg::CS_RUN)
      else $error("restart not immediate");

   a_start_reads_zero: assert property (
      regRd && regAddr == sac_pkg::ADDR_CTRL |=> !regRdData[sac_pkg::BIT_START])
      else $error("start bit read as one");

   a_irq_masked: assert property (
      !irqEn |=> !irqReq)
      else $error("interrupt while disabled");

   a_irq_done: assert property (
      doneTake && irqEn && mask[sac_pkg::STAT_DONE] && !regWr
      |=> ##1 irqReq)
      else $error("done interrupt missing");

   a_power_idle: assert property (
      !pwrOn |-> state == sac_pkg::CS_IDLE || $past(startReq))
      else $error("converter active while off");

   a_div_fast: assert property (
      tickPulse && fastClk && $stable(fastClk) && state == sac_pkg::CS_RUN
      && !startReq && !powerDown
      |-> ##[1:5] !tickPulse ##1 tickPulse || !(state == sac_pkg::CS_RUN))
      else $error("fast divider period wrong");

   a_sync_hold: assert property (
      state == sac_pkg::CS_SYNC && !coreInWait && !startReq && !powerDown
      |=> !startPulse)
      else $error("start before WAIT");

   a_reset_value: assert property (
      $rose(reset_n) |-> eoc && !irqEn && !irqReq)
      else $error("reset state wrong");

   a_done_sticky: assert property (
      eoc && !startReq |=> eoc)
      else $error("done flag lost");

   a_power_follows: assert property (
      wrCtrl |=> pwrOn == $past(regWrData[sac_pkg::BIT_PWR]))
      else $error("power bit not taken");

   a_power_abort: assert property (
      powerDown |=> abortPulse && state == sac_pkg::CS_IDLE)
      else $error("power down did not abort");

   a_fast_follows: assert property (
      wrCtrl |=> fastClk == $past(regWrData[sac_pkg::BIT_FAST]))
      else $error("clock select not taken");

   a_tick_idle: assert property (
      state != sac_pkg::CS_RUN |=> !tickPulse)
      else $error("tick outside conversion");

   a_osc_follows: assert property (
      wrCtrl |=> mainOscStop == $past(regWrData[sac_pkg::BIT_OSC]))
      else $error("oscillator bit not taken");

   a_reserved_zero: assert property (
      regRd && regAddr == sac_pkg::ADDR_CTRL |=> regRdData[1:0] == 2'h0)
      else $error("reserved bits read as one");

   a_result_read: assert property (
      regRd && regAddr == sac_pkg::ADDR_RESULT |=> regRdData == $past(result))
      else $error("result read wrong");

   a_read_idle: assert property (
      !regRd |=> regRdData == 8'h00)
      else $error("read data outside read cycle");

   a_dac_start: assert property (
      startPulse |=> dacCode == sac_pkg::TRIAL_START)
      else $error("trial code not reset at start");

   a_sync_abort: assert property (
      startReq && waitSyncOpt |=> abortPulse && state == sac_pkg::CS_SYNC)
      else $error("sync start not held");

   a_status_clear: assert property (
      rdStatus && !doneTake && !restartEv |=> status == 2'h0)
      else $error("status not cleared by read");

   a_irq_quiet: assert property (
      (status & mask) == 2'h0 |=> !irqReq)
      else $error("interrupt without event");

   c_plain_conv: cover property (
      startPulse ##[1:1000] doneTake);
   c_restart: cover property (
      restartEv && state == sac_pkg::CS_RUN);
   c_sync_start: cover property (
      state == sac_pkg::CS_SYNC ##1 startPulse);
   c_irq: cover property (
      $rose(irqReq));
   c_power_abort: cover property (powerDown && state == sac_pkg::CS_RUN);
endmodule : sac_adc_ctrl

//--- hw/sac_pkg.sv
package sac_pkg;
   // =====================================================
   // Register map
   localparam logic [7:0] ADDR_RESULT = 8'hD0;
   localparam logic [7:0] ADDR_CTRL   = 8'hD1;
   localparam logic [7:0] ADDR_STATUS = 8'hD2;
   localparam logic [7:0] ADDR_MASK   = 8'hD3;
   // =====================================================
   // Control register fields
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_DONE   = 6;
   localparam int BIT_START  = 5;
   localparam int BIT_PWR    = 4;
   localparam int BIT_FAST   = 3;
   localparam int BIT_OSC    = 2;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   // =====================================================
   // Event status and mask
   localparam int STAT_W       = 2;
   localparam int STAT_DONE    = 0;
   localparam int STAT_RESTART = 1;
   localparam logic [1:0] MASK_RESET = 2'h1;
   // =====================================================
   // Timing
   localparam int RES_W        = 8;
   localparam int DIV_SLOW     = 12;
   localparam int DIV_FAST     = 6;
   localparam logic [3:0] DIV_SLOW_LAST = 4'(DIV_SLOW - 1);
   localparam logic [3:0] DIV_FAST_LAST = 4'(DIV_FAST - 1);
   localparam int INT_CLK_KHZ  = 8000;
   localparam int CONV_TIME_NS = 70000;
   localparam int CONV_TICKS   =
      (CONV_TIME_NS * INT_CLK_KHZ) / (1000000 * DIV_SLOW);
   localparam logic [5:0] SETTLE_LAST = 6'(CONV_TICKS - RES_W - 1);
   localparam logic [2:0] BIT_MSB     = 3'(RES_W - 1);
   localparam logic [7:0] TRIAL_START = 8'h80;
   // =====================================================
   // States
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00,
      CS_SYNC = 2'b01,
      CS_RUN  = 2'b10
   } sac_ctl_state_t;
   typedef enum logic [1:0] {
      SS_IDLE   = 2'b00,
      SS_SETTLE = 2'b01,
      SS_BITS   = 2'b10
   } sac_sar_state_t;
endpackage : sac_pkg

//--- hw/sac_sar_if.sv
`timescale 1ns/1ps
interface sac_sar_if;
   logic       start;
   logic       abort;
   logic       tick;
   logic       compHigh;
   logic       done;
   logic [7:0] trial;
   logic [7:0] result;
   modport ctrl (output start, abort, tick, compHigh,
                 input  done, trial, result);
   modport core (input  start, abort, tick, compHigh,
                 output done, trial, result);
endinterface : sac_sar_if

//--- hw/sac_sar_core.sv
`timescale 1ns/1ps
module sac_sar_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Control side
   sac_sar_if.core  sar
);
   sac_pkg::sac_sar_state_t state;
   logic [5:0]              settleCnt;
   logic [2:0]              bitIdx;

   // =====================================================
   // Successive approximation, one bit per tick
   always_ff @(posedge sys_clk) begin
      sar.done <= 1'b0;
      if (!reset_n) begin
         state      <= sac_pkg::SS_IDLE;
         settleCnt  <= '0;
         bitIdx     <= '0;
         sar.trial  <= '0;
         sar.result <= '0;
      end else if (sar.abort) begin
         state <= sac_pkg::SS_IDLE;
      end else if (sar.start) begin
         // Restart wins over any tick in flight
         state     <= sac_pkg::SS_SETTLE;
         settleCnt <= '0;
         sar.trial <= sac_pkg::TRIAL_START;
      end else if (sar.tick) begin
         unique case (state)
            sac_pkg::SS_IDLE: begin
            end
            sac_pkg::SS_SETTLE: begin
               settleCnt <= settleCnt + 6'h01;
               if (settleCnt == sac_pkg::SETTLE_LAST) begin
                  state  <= sac_pkg::SS_BITS;
                  bitIdx <= sac_pkg::BIT_MSB;
               end
            end
            sac_pkg::SS_BITS: begin
               sar.trial[bitIdx] <= sar.compHigh;
               if (bitIdx != 3'h0) begin
                  sar.trial[bitIdx - 3'h1] <= 1'b1;
                  bitIdx <= bitIdx - 3'h1;
               end else begin
                  sar.result <= {sar.trial[7:1], sar.compHigh};
                  sar.done   <= 1'b1;
                  state      <= sac_pkg::SS_IDLE;
               end
            end
            default: state <= sac_pkg::SS_IDLE;
         endcase
      end
   end
endmodule : sac_sar_core

//--- bench/test_sac_adc_ctrl.sv
`timescale 1ns/1ps
`define CHK(act, exp) begin \
   nCompared++; \
   if ((act) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); \
   end \
end

module test_sac_adc_ctrl;
   // =====================================================
   // Signals
   localparam int LIMIT = 20000;
   logic       sys_clk;
   logic       reset_n;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic       compHigh;
   logic [7:0] dacCode;
   logic       converterPowerOn;
   logic       waitSyncOpt;
   logic       coreInWait;
   logic       mainOscStop;
   logic       irqReq;
   logic [7:0] vin;
   int         mismatches;
   int         nCompared;
   int         cycles;

   sac_adc_ctrl u_sac_adc_ctrl (
      .sys_clk          (sys_clk),
      .reset_n          (reset_n),
      .regAddr          (regAddr),
      .regWrData        (regWrData),
      .regWr            (regWr),
      .regRd            (regRd),
      .regRdData        (regRdData),
      .compHigh         (compHigh),
      .dacCode          (dacCode),
      .converterPowerOn (converterPowerOn),
      .waitSyncOpt      (waitSyncOpt),
      .coreInWait       (coreInWait),
      .mainOscStop      (mainOscStop),
      .irqReq           (irqReq)
   );

   // Analog input sits half a step above code vin
   assign compHigh = ((vin >= dacCode) === 1'b1);

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         give_verdict();
      end
   end

   // =====================================================
   // Bus and helpers
   function automatic logic [7:0] ctl(input logic ie, eo, st, pw, fs, os);
      ctl = 8'h00;
      ctl[sac_pkg::BIT_IRQ_EN] = ie;
      ctl[sac_pkg::BIT_DONE]   = eo;
      ctl[sac_pkg::BIT_START]  = st;
      ctl[sac_pkg::BIT_PWR]    = pw;
      ctl[sac_pkg::BIT_FAST]   = fs;
      ctl[sac_pkg::BIT_OSC]    = os;
   endfunction : ctl

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge sys_clk);
      regWr     <= 1'b0;
   endtask : wr

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      @(posedge sys_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge sys_clk);
      regRd   <= 1'b0;
      @(negedge sys_clk);
      d = regRdData;
      `CHK(d, exp)
   endtask : chk_rd

   // Let n edges pass, then sample mid-cycle
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle

   // Cycles from the current edge until irqReq rises, sampled mid-cycle
   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (irqReq !== 1'b1 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_irq

   task automatic chk_time(input int n, input int dv);
      int lo;
      lo = sac_pkg::CONV_TICKS * dv;
      `CHK((n >= lo) && (n <= lo + dv + 4), 1'b1)
   endtask : chk_time

   // =====================================================
   // Scenarios
   task automatic t_reset();
      chk_rd(sac_pkg::ADDR_CTRL, 8'h40);
      chk_rd(sac_pkg::ADDR_MASK, 8'h01);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
      `CHK(irqReq, 1'b0)
      `CHK(converterPowerOn, 1'b0)
   endtask : t_reset

   task automatic t_conv(input logic fs, input logic [7:0] v);
      int n;
      vin <= v;
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 1, fs, 0));
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, fs, 0));
      wait_irq(800, n);
      chk_time(n, fs ? 6 : 12);
      `CHK(dacCode, v)
      chk_rd(sac_pkg::ADDR_RESULT, v);
      chk_rd(sac_pkg::ADDR_CTRL, ctl(1, 1, 0, 1, fs, 0));
      chk_rd(sac_pkg::ADDR_STATUS, 8'h01);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
      settle(2);
      `CHK(irqReq, 1'b0)
      repeat (600) @(posedge sys_clk);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
   endtask : t_conv

   task automatic t_bus();
      wr(sac_pkg::ADDR_RESULT, 8'h5A);
      chk_rd(sac_pkg::ADDR_RESULT, 8'hFF);
      chk_rd(8'hD4, 8'h00);
   endtask : t_bus

   task automatic t_restart();
      int n;
      vin <= 8'h3C;
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 0, 0));
      chk_rd(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 1, 0, 0));
      repeat (100) @(posedge sys_clk);
      vin <= 8'hC3;
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 0, 0));
      wait_irq(800, n);
      chk_time(n, 12);
      chk_rd(sac_pkg::ADDR_RESULT, 8'hC3);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h03);
   endtask : t_restart

   task automatic t_mask();
      wr(sac_pkg::ADDR_CTRL, ctl(0, 0, 1, 1, 1, 0));
      settle(320);
      `CHK(irqReq, 1'b0)
      chk_rd(sac_pkg::ADDR_CTRL, ctl(0, 1, 0, 1, 1, 0));
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 1, 1, 0));
      settle(2);
      `CHK(irqReq, 1'b1)
      wr(sac_pkg::ADDR_MASK, 8'h00);
      settle(2);
      `CHK(irqReq, 1'b0)
      wr(sac_pkg::ADDR_MASK, 8'h01);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h01);
   endtask : t_mask

   task automatic t_power();
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 0, 0, 1));
      settle(2);
      `CHK(converterPowerOn, 1'b0)
      `CHK(mainOscStop, 1'b1)
      repeat (600) @(posedge sys_clk);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 1, 0, 0));
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 0, 0));
      settle(100);
      `CHK(converterPowerOn, 1'b1)
      `CHK(mainOscStop, 1'b0)
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 0, 0, 0));
      repeat (600) @(posedge sys_clk);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
      `CHK(irqReq, 1'b0)
   endtask : t_power

   task automatic t_sync();
      int n;
      vin         <= 8'h81;
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 0, 1, 1, 0));
      waitSyncOpt <= 1'b1;
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 1, 0));
      settle(20);
      `CHK(irqReq, 1'b0)
      @(posedge sys_clk);
      coreInWait <= 1'b1;
      wait_irq(400, n);
      chk_time(n, 6);
      chk_rd(sac_pkg::ADDR_RESULT, 8'h81);
      chk_rd(sac_pkg::ADDR_STATUS, 8'h01);
      @(posedge sys_clk);
      waitSyncOpt <= 1'b0;
      coreInWait  <= 1'b0;
   endtask : t_sync

   task automatic t_reset_abort();
      wr(sac_pkg::ADDR_CTRL, ctl(1, 0, 1, 1, 0, 0));
      repeat (100) @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      chk_rd(sac_pkg::ADDR_CTRL, 8'h40);
      settle(600);
      `CHK(irqReq, 1'b0)
      chk_rd(sac_pkg::ADDR_STATUS, 8'h00);
   endtask : t_reset_abort

   // =====================================================
   // Verdict and main sequence
   task automatic give_verdict();
      if (mismatches == 0 && nCompared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   initial begin
      reset_n     = 1'b0;
      regAddr     = 8'h00;
      regWrData   = 8'h00;
      regWr       = 1'b0;
      regRd       = 1'b0;
      waitSyncOpt = 1'b0;
      coreInWait  = 1'b0;
      vin         = 8'h00;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_conv(1'b0, 8'hA5);
      t_conv(1'b1, 8'h00);
      t_conv(1'b0, 8'hFF);
      t_bus();
      t_restart();
      t_mask();
      t_power();
      t_sync();
      t_reset_abort();
      give_verdict();
   end
endmodule : test_sac_adc_ctrl
